/* design/loc_params.svh */
// constants for the logic array output cell block: offsets, fields, reset values
`ifndef LOC_PARAMS_SVH
`define LOC_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LOC_OFS_MODE 8'h00
`define LOC_OFS_PROG 8'h04
`define LOC_OFS_VERIFY 8'h08
`define LOC_OFS_LOCK 8'h0c
`define LOC_OFS_PINS 8'h10
`define LOC_OFS_CELLS 8'h14

// ----------------------------------------
// program command fields
// ----------------------------------------
`define LOC_PROG_TGT_LSB 0
`define LOC_PROG_TGT_MSB 1
`define LOC_PROG_DATA_BIT 4
`define LOC_PROG_VERIFY_BIT 5
`define LOC_PROG_ERASE_BIT 6
`define LOC_PROG_ROW_LSB 8
`define LOC_PROG_ROW_MSB 11
`define LOC_PROG_COL_LSB 16
`define LOC_PROG_COL_MSB 23

// ----------------------------------------
// cell architecture bit positions
// ----------------------------------------
`define LOC_ARCH_POL 0
`define LOC_ARCH_MODE 1
`define LOC_ARCH_OE 2

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define LOC_MODE_RST 3'h0
`define LOC_RESP_OKAY 2'h0
`define LOC_RESP_SLVERR 2'h2
`define LOC_TOP_CELL 0
`define LOC_BOTTOM_CELL 9

`endif

/* design/loc_pkg.sv */
// types shared by the logic array output cell block
package loc_pkg;

    // operating mode, stands in for the supervoltage selects
    typedef enum logic [2:0] {
        LOC_NORMAL = 3'h0,
        LOC_PHANTOM = 3'h1,
        LOC_TOP_TEST = 3'h2,
        LOC_BOTTOM_TEST = 3'h3,
        LOC_PRELOAD = 3'h4
    } loc_mode_type;

    // programmable areas addressed by row and column
    typedef enum logic [1:0] {
        LOC_TGT_ARCH = 2'h0,
        LOC_TGT_PHANTOM = 2'h1,
        LOC_TGT_TOP = 2'h2,
        LOC_TGT_BOTTOM = 2'h3
    } loc_target_type;

endpackage : loc_pkg

/* design/loc_output_cell.sv */
// one configurable output cell: register, polarity, enable select and feedback
`timescale 1ns/1ns
`include "loc_params.svh"

module loc_output_cell (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] arch_i,
    input wire logic sum_i,
    input wire logic oe_term_i,
    input wire logic oe_pin_n_i,
    input wire logic dev_clk_edge_i,
    input wire logic preload_i,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n_o,
    output logic feedback_o,
    output logic q_o
);

    logic q, next_q;
    logic pin_out, next_pin_out;
    logic pin_oe_n, next_pin_oe_n;
    logic feedback, next_feedback;
    logic path_val;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb begin
        next_q = q;
        if (dev_clk_edge_i) begin
            // preload takes the pin level; a one loads one
            next_q = preload_i ? pin_i : sum_i;
        end
        // combinational or registered path
        path_val = arch_i[`LOC_ARCH_MODE] ? sum_i : next_q;
        // polarity sits just before the driver, the register never sees it
        next_pin_out = arch_i[`LOC_ARCH_POL] ? path_val : ~path_val;
        if (preload_i) begin
            next_pin_oe_n = 1'b1;
        end else if (arch_i[`LOC_ARCH_OE]) begin
            next_pin_oe_n = oe_pin_n_i;
        end else begin
            // enable term low leaves the pin as a pure input
            next_pin_oe_n = ~oe_term_i;
        end
        // a registered cell feeds its register back whether or not its driver is on
        next_feedback = arch_i[`LOC_ARCH_MODE] ? pin_i : next_q;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            q <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            feedback <= 1'b0;
        end else begin
            q <= next_q;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            feedback <= next_feedback;
        end
    end

    assign pin_o = pin_out;
    assign pin_oe_n_o = pin_oe_n;
    assign feedback_o = feedback;
    assign q_o = q;

endmodule : loc_output_cell

/* design/loc_array_top.sv */
// output cells, programmable test arrays, readback lock and the AXI4-Lite slave
//
// Operation
// - ten output cells, each set only by its own architecture bits
// - per cell: one polarity bit, one register/combinational bit, one enable-source bit
// - registered cell feeds its register back into the array
// - combinational cell feeds its pin back into the array
// - combinational cell with enable term off acts as plain input
// - no buried register while pin serves as combinational output or input
// - lock set refuses verify of user array and upper/lower test terms
// - factory test array stays programmable and verifiable under lock
// - lock changes nothing but readback
// - factory array adds four columns, three true one inverted, on every term
// - factory array has no effect in normal mode
// - upper/lower test terms drive one designated pin each, only in test modes
// - architecture bits are their own program target
// - all locations but the lock use row/column address and one procedure
// - lock state reads back on its own register
// - test modes only while the mode select holds them
// - all-zero bits: term enable, registered, active low; each bit flips one
// - registers clock on device clock pin, start low after reset
// - preload: drivers off, pin data loaded on device clock edge
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "loc_params.svh"

module loc_array_top #(
    parameter int NUM_CELLS = 10,
    parameter int NUM_INPUTS = 22,
    parameter int NUM_TEST_COLS = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic dev_clk_i,
    input wire logic oe_pin_n_i,
    input wire logic [NUM_INPUTS-1:0] array_in_i,
    input wire logic [NUM_TEST_COLS-1:0] test_col_in_i,
    input wire logic [NUM_CELLS-1:0] sum_term_i,
    input wire logic [NUM_CELLS-1:0] oe_term_i,
    input wire logic [NUM_CELLS-1:0] pin_i,
    output logic [NUM_CELLS-1:0] pin_o,
    output logic [NUM_CELLS-1:0] pin_oe_n_o,
    output logic [NUM_CELLS-1:0] feedback_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    loc_pkg::loc_mode_type mode, next_mode;
    logic [2:0] arch [NUM_CELLS], next_arch [NUM_CELLS];
    logic [NUM_TEST_COLS-1:0] ph_mask [NUM_CELLS], next_ph_mask [NUM_CELLS];
    logic [NUM_INPUTS-1:0] top_mask, next_top_mask;
    logic [NUM_INPUTS-1:0] bot_mask, next_bot_mask;
    logic lock, next_lock;
    logic verify_data, next_verify_data;
    logic verify_refused, next_verify_refused;
    logic dev_clk_prev, dev_clk_edge;
    logic [NUM_CELLS-1:0] cell_q;
    logic aw_full, next_aw_full;
    logic [7:0] aw_addr, next_aw_addr;
    logic w_full, next_w_full;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic awready, next_awready;
    logic wready, next_wready;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic arready, next_arready;

    // ----------------------------------------
    // array terms
    // ----------------------------------------
    logic [NUM_TEST_COLS-1:0] test_cols;
    logic [NUM_CELLS-1:0] cell_sum;
    logic top_term, bot_term;
    logic wr_fire;
    logic [31:0] wmask, wval;
    logic [1:0] tgt;
    logic [3:0] row;
    logic [7:0] col;
    // second column is the inverting input
    assign test_cols = test_col_in_i ^ {{(NUM_TEST_COLS-2){1'b0}}, 2'b10};
    // an unprogrammed term has no connection and stays low
    assign top_term = (|top_mask) & (&(array_in_i | ~top_mask));
    assign bot_term = (|bot_mask) & (&(array_in_i | ~bot_mask));
    assign dev_clk_edge = dev_clk_i & ~dev_clk_prev;

    always_comb begin
        for (int i = 0; i < NUM_CELLS; i++) begin
            cell_sum[i] = sum_term_i[i];
            if (mode == loc_pkg::LOC_PHANTOM) begin
                cell_sum[i] = (|ph_mask[i]) & (&(test_cols | ~ph_mask[i]));
            end
        end
        // extra terms only reach their pin inside their own test mode
        if (mode == loc_pkg::LOC_TOP_TEST) begin
            cell_sum[`LOC_TOP_CELL] = top_term;
        end
        if (mode == loc_pkg::LOC_BOTTOM_TEST) begin
            cell_sum[`LOC_BOTTOM_CELL] = bot_term;
        end
    end

    // ----------------------------------------
    // output cells
    // ----------------------------------------
    for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
        // each cell sees only its own three bits
        loc_output_cell u_cell (
            .sys_clk_i(sys_clk_i),
            .rst_b_i(rst_b_i),
            .arch_i(arch[g]),
            .sum_i(cell_sum[g]),
            .oe_term_i(oe_term_i[g]),
            .oe_pin_n_i(oe_pin_n_i),
            .dev_clk_edge_i(dev_clk_edge),
            .preload_i(mode == loc_pkg::LOC_PRELOAD),
            .pin_i(pin_i[g]),
            .pin_o(pin_o[g]),
            .pin_oe_n_o(pin_oe_n_o[g]),
            .feedback_o(feedback_o[g]),
            .q_o(cell_q[g])
        );
    end

    // ----------------------------------------
    // bus write channel
    // ----------------------------------------
    assign wr_fire = aw_full & w_full & ~bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wval = w_data & wmask;
    assign tgt = wval[`LOC_PROG_TGT_MSB:`LOC_PROG_TGT_LSB];
    assign row = wval[`LOC_PROG_ROW_MSB:`LOC_PROG_ROW_LSB];
    assign col = wval[`LOC_PROG_COL_MSB:`LOC_PROG_COL_LSB];

    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        // address and data are taken in either order
        if (s_axi_awvalid_i && awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                `LOC_OFS_MODE, `LOC_OFS_PROG, `LOC_OFS_LOCK: next_bresp = `LOC_RESP_OKAY;
                `LOC_OFS_VERIFY, `LOC_OFS_PINS, `LOC_OFS_CELLS: next_bresp = `LOC_RESP_OKAY;
                default: next_bresp = `LOC_RESP_SLVERR;
            endcase
        end else if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        next_awready = ~next_aw_full & ~next_bvalid;
        next_wready = ~next_w_full & ~next_bvalid;
    end

    // ----------------------------------------
    // programming, verify and lock
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        next_arch = arch;
        next_ph_mask = ph_mask;
        next_top_mask = top_mask;
        next_bot_mask = bot_mask;
        next_lock = lock;
        next_verify_data = verify_data;
        next_verify_refused = verify_refused;
        if (wr_fire && aw_addr == `LOC_OFS_MODE && w_strb[0] && w_data[2:0] <= 3'h4) begin
            next_mode = loc_pkg::loc_mode_type'(w_data[2:0]);
        end
        // the lock has its own command, no row or column
        if (wr_fire && aw_addr == `LOC_OFS_LOCK && w_strb[0] && w_data[0]) begin
            next_lock = 1'b1;
        end
        // one procedure for every row/column location
        if (wr_fire && aw_addr == `LOC_OFS_PROG && w_strb[0]) begin
            if (wval[`LOC_PROG_ERASE_BIT]) begin
                // erase blanks every location and the lock
                next_arch = '{default: 3'h0};
                next_ph_mask = '{default: '0};
                next_top_mask = '0;
                next_bot_mask = '0;
                next_lock = 1'b0;
                next_verify_refused = 1'b0;
            end else if (wval[`LOC_PROG_VERIFY_BIT]) begin
                // lock hides all but the factory array
                next_verify_refused = lock & (tgt != loc_pkg::LOC_TGT_PHANTOM);
                next_verify_data = 1'b0;
                if (!(lock && tgt != loc_pkg::LOC_TGT_PHANTOM) && row < NUM_CELLS) begin
                    case (tgt)
                        loc_pkg::LOC_TGT_ARCH: next_verify_data = (col < 8'h03) && arch[row][col[1:0]];
                        loc_pkg::LOC_TGT_PHANTOM: next_verify_data = (col < NUM_TEST_COLS) && ph_mask[row][col[1:0]];
                        loc_pkg::LOC_TGT_TOP: next_verify_data = (col < NUM_INPUTS) && top_mask[col[4:0]];
                        loc_pkg::LOC_TGT_BOTTOM: next_verify_data = (col < NUM_INPUTS) && bot_mask[col[4:0]];
                        default: next_verify_data = 1'b0;
                    endcase
                end
            end else if (wval[`LOC_PROG_DATA_BIT] && row < NUM_CELLS) begin
                // a one programs, a zero leaves the location as it was
                case (tgt)
                    loc_pkg::LOC_TGT_ARCH: if (col < 8'h03) next_arch[row][col[1:0]] = 1'b1;
                    loc_pkg::LOC_TGT_PHANTOM: if (col < NUM_TEST_COLS) next_ph_mask[row][col[1:0]] = 1'b1;
                    loc_pkg::LOC_TGT_TOP: if (col < NUM_INPUTS) next_top_mask[col[4:0]] = 1'b1;
                    loc_pkg::LOC_TGT_BOTTOM: if (col < NUM_INPUTS) next_bot_mask[col[4:0]] = 1'b1;
                    default: next_lock = lock;
                endcase
            end
        end
    end

    // ----------------------------------------
    // bus read channel
    // ----------------------------------------
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid_i && arready) begin
            next_rvalid = 1'b1;
            next_rresp = `LOC_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case (s_axi_araddr_i)
                `LOC_OFS_MODE: next_rdata = {29'h0000_0000, mode};
                `LOC_OFS_PROG: next_rdata = 32'h0000_0000;
                `LOC_OFS_VERIFY: next_rdata = {30'h0000_0000, verify_refused, verify_data};
                `LOC_OFS_LOCK: next_rdata = {31'h0000_0000, lock};
                `LOC_OFS_PINS: next_rdata = {2'h0, ~pin_oe_n_o, pin_o, feedback_o};
                `LOC_OFS_CELLS: next_rdata = {22'h00_0000, cell_q};
                default: next_rresp = `LOC_RESP_SLVERR;
            endcase
        end else if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        next_arready = ~next_rvalid;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mode <= loc_pkg::LOC_NORMAL;
            arch <= '{default: 3'h0};
            ph_mask <= '{default: '0};
            top_mask <= '0;
            bot_mask <= '0;
            lock <= 1'b0;
            verify_data <= 1'b0;
            verify_refused <= 1'b0;
            dev_clk_prev <= 1'b0;
            aw_full <= 1'b0;
            aw_addr <= 8'h00;
            w_full <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `LOC_RESP_OKAY;
            awready <= 1'b0;
            wready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `LOC_RESP_OKAY;
            arready <= 1'b0;
        end else begin
            mode <= next_mode;
            arch <= next_arch;
            ph_mask <= next_ph_mask;
            top_mask <= next_top_mask;
            bot_mask <= next_bot_mask;
            lock <= next_lock;
            verify_data <= next_verify_data;
            verify_refused <= next_verify_refused;
            dev_clk_prev <= dev_clk_i;
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            awready <= next_awready;
            wready <= next_wready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            arready <= next_arready;
        end
    end

    assign s_axi_awready_o = awready;
    assign s_axi_wready_o = wready;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_arready_o = arready;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
endmodule : loc_array_top

/* bench/loc_array_chk.sv */
// checker for the output cell block: bus handshakes, reset state and pin enables
`timescale 1ns/1ns
`include "loc_params.svh"

module loc_array_chk #(
    parameter int NUM_CELLS = 10
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic oe_pin_n_i,
    input wire logic [NUM_CELLS-1:0] oe_term_i,
    input wire logic [NUM_CELLS-1:0] pin_oe_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_RST_OUT: assert property ($rose(rst_b_i) |-> pin_oe_n_o == '1 && !s_axi_bvalid_o && !s_axi_rvalid_o)
        else $error("outputs wrong after reset");
    // a driver is on only if an enable source asked
    AST_OE_CAUSE: assert property ((~pin_oe_n_o & ~$past(oe_term_i) & {NUM_CELLS{$past(oe_pin_n_i)}}) == '0)
        else $error("pin driven with no enable source");
    // both words are buffered one edge, the answer registers on the next
    AST_W_ANS: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    AST_W_REFUSE: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    AST_B_FALL: assert property ($fell(s_axi_bvalid_o) |-> $past(s_axi_bready_i))
        else $error("write response dropped without bready");
    AST_R_ANS: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read data late");
    AST_R_FALL: assert property ($fell(s_axi_rvalid_o) |-> $past(s_axi_rready_i))
        else $error("read data dropped without rready");
    AST_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i >= 8'h18
        |=> s_axi_rresp_o == `LOC_RESP_SLVERR && s_axi_rdata_o == '0)
        else $error("unmapped read not refused");

    AST_COV_WRITE: cover property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o);
    AST_COV_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);
    AST_COV_DRIVE: cover property (pin_oe_n_o != '1);
endmodule : loc_array_chk

bind loc_array_top loc_array_chk #(.NUM_CELLS(NUM_CELLS)) i_chk (
    .sys_clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .oe_pin_n_i, .oe_term_i, .pin_oe_n_o
);

/* bench/loc_board.sv */
// board model: resolves the ten cell pins from device and board drivers
`timescale 1ns/1ns

module loc_board (
    input wire logic sys_clk_i,
    input wire logic [9:0] dev_val_i,
    input wire logic [9:0] dev_oe_n_i,
    input wire logic [9:0] ext_val_i,
    input wire logic [9:0] ext_en_i,
    output logic [9:0] pin_lvl_o
);
    logic [9:0] float_q = 10'h155;
    // undriven pin toggles so no test leans on its level
    always_ff @(posedge sys_clk_i) float_q <= ~float_q;
    // board data reaches the pin only while the cell driver is off
    always_comb pin_lvl_o = (~dev_oe_n_i & dev_val_i) | (dev_oe_n_i & ext_en_i & ext_val_i)
        | (dev_oe_n_i & ~ext_en_i & float_q);
endmodule : loc_board

/* bench/logic_array_output_cells_tb.sv */
// self-checking testbench for the output cell block
`timescale 1ns/1ns
`include "loc_params.svh"

module logic_array_output_cells_tb;
    localparam logic [1:0] T_AR = loc_pkg::LOC_TGT_ARCH;
    localparam logic [1:0] T_PH = loc_pkg::LOC_TGT_PHANTOM;
    localparam logic [1:0] T_UP = loc_pkg::LOC_TGT_TOP;
    localparam logic [1:0] T_LO = loc_pkg::LOC_TGT_BOTTOM;
    logic clk = 1'h0, rst_b = 1'h0, aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic dev = 1'h0, oe_pn = 1'h1, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
    logic [31:0] w_d = 32'h0, r_d;
    logic [1:0] b_resp, r_resp;
    logic [21:0] a_in = 22'h0;
    logic [3:0] t_col = 4'h0;
    logic [9:0] sum = 10'h0, oe_t = 10'h0, ext = 10'h0, ext_en = 10'h0, p_o, p_oen, fb, p_i;
    int fails = 0, n_checks = 0;

    always #10 clk = ~clk;

    loc_array_top i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
        .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v),
        .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d),
        .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .dev_clk_i(dev),
        .oe_pin_n_i(oe_pn), .array_in_i(a_in), .test_col_in_i(t_col), .sum_term_i(sum), .oe_term_i(oe_t),
        .pin_i(p_i), .pin_o(p_o), .pin_oe_n_o(p_oen), .feedback_o(fb));
    loc_board i_board (.sys_clk_i(clk), .dev_val_i(p_o), .dev_oe_n_i(p_oen), .ext_val_i(ext),
        .ext_en_i(ext_en), .pin_lvl_o(p_i));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'h1;
        w_v <= 1'h1;
        b_r <= 1'h1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 1'h0;
            if (w_rdy) w_v <= 1'h0;
        end while (!b_v);
        b_r <= 1'h0;
        chk("bresp", b_resp, `LOC_RESP_OKAY);
    endtask : wr

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'h1;
        r_r <= 1'h1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 1'h0;
        end while (!r_v);
        r_r <= 1'h0;
        chk(n, r_d, e);
        chk("rresp", r_resp, er);
    endtask : rc

    task automatic prog(input logic [1:0] t, input logic [3:0] r, input logic [7:0] c, input logic [2:0] f);
        wr(`LOC_OFS_PROG, {8'h00, c, 4'h0, r, 1'h0, f, 2'h0, t});
    endtask : prog

    task automatic vfy(input logic [1:0] t, input logic [3:0] r, input logic [7:0] c, input logic [1:0] e);
        prog(t, r, c, 3'h2);
        rc("verify", `LOC_OFS_VERIFY, {30'h0, e}, `LOC_RESP_OKAY);
    endtask : vfy

    // slow device clock: only sampled edges count
    task automatic dpulse;
        @(posedge clk);
        dev <= 1'h1;
        repeat (3) @(posedge clk);
        dev <= 1'h0;
        settle;
    endtask : dpulse

    task automatic t_reset;
        chk("pin_o", p_o, 10'h3ff);
        chk("oe_n", p_oen, 10'h3ff);
        rc("mode", `LOC_OFS_MODE, 32'h0, `LOC_RESP_OKAY);
        rc("cells", `LOC_OFS_CELLS, 32'h0, `LOC_RESP_OKAY);
        rc("pins", `LOC_OFS_PINS, 32'h000f_fc00, `LOC_RESP_OKAY);
        rc("hole", 8'h40, 32'h0, `LOC_RESP_SLVERR);
    endtask : t_reset

    task automatic t_arch;
        for (int k = 0; k < 8; k++) begin
            prog(T_AR, 4'h0, 8'h00, 3'h4);
            sum <= 10'h000;
            dpulse;
            for (int b = 0; b < 3; b++) if (k[b]) prog(T_AR, 4'h3, 8'(b), 3'h1);
            @(posedge clk);
            sum <= 10'h008;
            oe_t <= 10'h008;
            oe_pn <= k[1];
            settle;
            chk("comb", p_o[3], k[0] == k[1]);
            chk("oe_n", p_oen[3], k[2] ? k[1] : 1'h0);
            dpulse;
            chk("reg", p_o[3], k[0]);
            chk("other", {p_o[4], p_oen[4]}, 2'h3);
        end
        @(posedge clk);
        sum <= 10'h000;
        oe_t <= 10'h000;
    endtask : t_arch

    task automatic t_fb;
        prog(T_AR, 4'h0, 8'h00, 3'h4);
        prog(T_AR, 4'h5, 8'h01, 3'h1);
        sum <= 10'h040;
        ext <= 10'h020;
        ext_en <= 10'h060;
        dpulse;
        chk("fb", fb[6:5], 2'h3);
        @(posedge clk);
        ext <= 10'h000;
        settle;
        chk("fb", fb[6:5], 2'h2);
        @(posedge clk);
        sum <= 10'h000;
        ext_en <= 10'h000;
    endtask : t_fb

    task automatic t_test;
        logic [2:0] ex [4] = '{3'h0, 3'h2, 3'h1, 3'h4};
        prog(T_AR, 4'h0, 8'h00, 3'h4);
        for (int c = 0; c < 10; c++) for (int b = 0; b < 2; b++) prog(T_AR, 4'(c), 8'(b), 3'h1);
        prog(T_PH, 4'h2, 8'h00, 3'h1);
        prog(T_PH, 4'h2, 8'h01, 3'h1);
        prog(T_UP, 4'h0, 8'h05, 3'h1);
        prog(T_LO, 4'h9, 8'h07, 3'h1);
        t_col <= 4'h1;
        a_in <= 22'h0000a0;
        for (int m = 0; m < 4; m++) begin
            wr(`LOC_OFS_MODE, 32'(m));
            settle;
            chk("test", {p_o[9], p_o[2], p_o[0]}, ex[m]);
        end
        @(posedge clk);
        t_col <= 4'h3;
        wr(`LOC_OFS_MODE, 32'h1);
        settle;
        chk("inv", p_o[2], 1'h0);
        wr(`LOC_OFS_MODE, 32'h0);
    endtask : t_test

    task automatic t_pre;
        wr(`LOC_OFS_MODE, {29'h0, loc_pkg::LOC_PRELOAD});
        ext <= 10'h2a5;
        ext_en <= 10'h3ff;
        dpulse;
        chk("oe_n", p_oen, 10'h3ff);
        rc("cells", `LOC_OFS_CELLS, 32'h2a5, `LOC_RESP_OKAY);
        wr(`LOC_OFS_MODE, 32'h0);
        ext_en <= 10'h000;
    endtask : t_pre

    task automatic t_lock;
        prog(T_AR, 4'h0, 8'h00, 3'h4);
        prog(T_AR, 4'h1, 8'h00, 3'h1);
        prog(T_AR, 4'h1, 8'h01, 3'h0);
        vfy(T_AR, 4'h1, 8'h00, 2'h1);
        vfy(T_AR, 4'h1, 8'h01, 2'h0);
        wr(`LOC_OFS_LOCK, 32'h1);
        rc("lock", `LOC_OFS_LOCK, 32'h1, `LOC_RESP_OKAY);
        vfy(T_AR, 4'h1, 8'h00, 2'h2);
        vfy(T_UP, 4'h0, 8'h05, 2'h2);
        prog(T_PH, 4'h1, 8'h02, 3'h1);
        vfy(T_PH, 4'h1, 8'h02, 2'h1);
        dpulse;
        chk("pins", p_o[1:0], 2'h1);
    endtask : t_lock

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        settle;
        t_reset;
        t_arch;
        t_fb;
        t_test;
        t_pre;
        t_lock;
        summarize;
    end

    // ample margin over the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize;
    end
endmodule : logic_array_output_cells_tb
